//--- verif/tb_top.sv
// Purpose: self-checking bench of the in-band flow control block
// Assumes: AXI4-Lite master tasks here, peer model on the byte ports
// Notes: flow characters differ from every data byte used except 5a, sent once unpaired as data
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic rxValid, txOutValid, txOutReady;
  logic [7:0] rxData, txOutData;
  int mismatches = 0, compares = 0;
  // halt 5a then a5, resume 30 then 31
  localparam logic [31:0] FC = 32'ha55a_3130;
  uart_inband_flow i_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxValid, .rxData, .txOutValid,
    .txOutData, .txOutReady);
  uart_peer_model i_peer (.clk, .txOutValid, .txOutData, .txOutReady, .rxValid, .rxData);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // bus tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // no cycle limit here: a hung bus is left to the watchdog
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic stat;
    axr(uart_flow_pkg::OFF_STATUS);
  endtask : stat
  task automatic pop;
    axr(uart_flow_pkg::OFF_RXDATA);
  endtask : pop
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    axr(uart_flow_pkg::OFF_CHARS);
    chk(v, uart_flow_pkg::CHARS_RESET);
    axr(8'h14);
    chk(32'(r), 32'(uart_flow_pkg::RESP_SLVERR));
    axw(8'h14, 32'h1);
    chk(32'(r), 32'(uart_flow_pkg::RESP_SLVERR));
    // only lane 1 enabled: the other three characters stay at zero
    axw(uart_flow_pkg::OFF_CHARS, 32'hffff_ffff, 4'h2);
    axr(uart_flow_pkg::OFF_CHARS);
    chk(v, 32'h0000_ff00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_rxflow;
    axw(uart_flow_pkg::OFF_CHARS, FC);
    axr(uart_flow_pkg::OFF_CHARS);
    chk(v, FC);
    axw(uart_flow_pkg::OFF_CTRL, 32'h0b);
    i_peer.send(8'h5a);
    i_peer.send(8'ha5);
    axw(uart_flow_pkg::OFF_TXDATA, 32'h55);
    repeat (20) @(posedge clk);
    chk(32'(i_peer.got.size()), 32'd0);
    stat;
    chk(v[11:0], 12'h600);
    i_peer.send(8'h30);
    i_peer.send(8'h31);
    repeat (20) @(posedge clk);
    chk(i_peer.got[0], 8'h55);
    i_peer.send(8'h5a);
    i_peer.send(8'h41);
    stat;
    chk(v[11:0], 12'h002);
    pop;
    chk(v[8:0], 9'h15a);
    pop;
    chk(v[8:0], 9'h141);
    $display("test rx flow done");
  endtask : t_rxflow
  task automatic t_txflow;
    i_peer.got.delete();
    i_peer.slow = 1'b1;
    axw(uart_flow_pkg::OFF_CTRL, 32'h77);
    for (int i = 1; i <= 16; i++) begin
      if (i == 16) chk(32'(i_peer.got.size()), 32'd0);
      i_peer.send(8'(i));
    end
    repeat (30) @(posedge clk);
    chk(i_peer.got[0], 8'h5a);
    chk(i_peer.got[1], 8'ha5);
    stat;
    chk(v[11], 1'b1);
    chk(32'(v[5:0] >= 6'h10 && v[5:0] <= 6'h13), 32'd1);
    for (int i = 1; i <= 8; i++) begin
      if (i == 8) chk(32'(i_peer.got.size()), 32'd2);
      pop;
      chk(v[8:0], {1'b1, 8'(i)});
    end
    repeat (30) @(posedge clk);
    chk({i_peer.got[2], i_peer.got[3]}, 16'h3031);
    $display("test tx flow done");
  endtask : t_txflow
  task automatic t_nofifo;
    axw(uart_flow_pkg::OFF_CTRL, 32'h80);
    i_peer.send(8'h11);
    i_peer.send(8'h22);
    stat;
    chk(v[8:0], 9'h101);
    axw(uart_flow_pkg::OFF_STATUS, 32'h100, 4'h1);
    stat;
    chk(v[8], 1'b1);
    axw(uart_flow_pkg::OFF_STATUS, 32'h100, 4'h2);
    stat;
    chk(v[8], 1'b0);
    pop;
    chk(v[8:0], 9'h111);
    // flush plus preset eight: halt pair goes out at a fill of eight
    axw(uart_flow_pkg::OFF_CTRL, 32'hd7);
    for (int i = 1; i <= 8; i++) begin
      if (i == 8) chk(32'(i_peer.got.size()), 32'd4);
      i_peer.send(8'(i));
    end
    repeat (30) @(posedge clk);
    chk({i_peer.got[4], i_peer.got[5]}, 16'h5aa5);
    $display("test no fifo done");
  endtask : t_nofifo
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  initial begin
    arst_n <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_rxflow;
    t_txflow;
    t_nofifo;
    stop_test;
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule : tb_top

//--- verif/uart_peer_model.sv
// Purpose: far-end serial port that shares the block's byte ports
// Assumes: bench calls send; bytes go out five cycles apart
// Notes: slow mode toggles txOutReady to stall the block's transmitter
module uart_peer_model (
  input wire logic clk, // system clock
  input wire logic txOutValid, // byte offered by the block
  input wire logic [7:0] txOutData, // byte from the block
  output logic txOutReady, // peer takes the byte
  output logic rxValid, // byte strobe into the block
  output logic [7:0] rxData // byte into the block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow = 1'b0;
  logic [7:0] got[$];
  initial begin
    txOutReady = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
  end
  always @(posedge clk) begin
    if (txOutValid && txOutReady) got.push_back(txOutData);
    txOutReady <= slow ? ~txOutReady : 1'b1;
  end
  // same flow characters as the block are chosen by the bench
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge clk);
    rxValid <= 1'b0;
    rxData <= ~b; // no stale byte after the strobe
    repeat (3) @(posedge clk);
  endtask : send
endmodule : uart_peer_model

//--- verilog/uart_fifo_mem.sv
// Purpose: storage array of the receive fifo
// Assumes: one write and one read port on clk
// Notes: read data come out of a register, one cycle after the address
module uart_fifo_mem (
  input wire logic clk, // system clock
  input wire logic wrEn, // write strobe
  input wire logic [uart_flow_pkg::PTR_W-1:0] wrAddr, // write address
  input wire logic [uart_flow_pkg::DATA_W-1:0] wrData, // write data
  input wire logic [uart_flow_pkg::PTR_W-1:0] rdAddr, // read address
  output logic [uart_flow_pkg::DATA_W-1:0] rdData_ff // registered read data
);

  logic [uart_flow_pkg::DATA_W-1:0] mem [uart_flow_pkg::FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData_ff <= mem[rdAddr];
  end

endmodule : uart_fifo_mem

//--- verilog/uart_flow_pkg.sv
// Purpose: constants, register map and types of the in-band flow control block
// Assumes: 32-bit AXI4-Lite register bus, byte stream from a receiver on clk
// Notes: every register takes one aligned word; reserved bits read as zero
package uart_flow_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CHARS = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_TXDATA = 8'h10;

  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_FLUSH_BIT = 7;
  localparam int unsigned STAT_OVR_BIT = 8;
  localparam int unsigned STAT_TXHOLD_BIT = 9;
  localparam int unsigned STAT_TXHALT_BIT = 10;
  localparam int unsigned STAT_PEERHALT_BIT = 11;
  localparam int unsigned RXDATA_VALID_BIT = 8;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam logic [31:0] CHARS_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // receive fifo and trigger levels
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned PTR_W = 5;
  localparam int unsigned CNT_W = 6;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 6'h20;
  localparam logic [CNT_W-1:0] SINGLE_FULL_CNT = 6'h01;

  localparam logic [1:0] TRIG_ONE = 2'h0;
  localparam logic [1:0] TRIG_FOUR = 2'h1;
  localparam logic [1:0] TRIG_EIGHT = 2'h2;
  localparam logic [1:0] RX_TRIGGER_SIXTEEN = 2'h3;
  localparam logic [CNT_W-1:0] LVL_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] LVL_ONE = 6'h01;
  localparam logic [CNT_W-1:0] LVL_FOUR = 6'h04;
  localparam logic [CNT_W-1:0] LVL_EIGHT = 6'h08;
  localparam logic [CNT_W-1:0] LVL_SIXTEEN = 6'h10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] trigSel;
    logic usePresetRxTrigger;
    logic rxDualCharFlowCombo;
    logic txDualCharFlowCombo;
    logic inbandFlowSelect;
    logic fifoEn;
  } ctrl_s;

  typedef struct packed {
    logic [7:0] haltSecond;
    logic [7:0] haltFirst;
    logic [7:0] resumeSecond;
    logic [7:0] resumeFirst;
  } chars_s;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_SECOND = 2'h1
  } seq_e;

endpackage : uart_flow_pkg

//--- verilog/uart_inband_flow.sv
// Purpose: receive fifo with in-band two-character halt and resume flow control
// Assumes: received bytes arrive as one-cycle pulses at least two cycles apart
// Notes: registers over AXI4-Lite; flow characters go out ahead of host data

// Contract
// - With transmit flow and the preset trigger on, send halt first/second at the halt level and resume pair later.
// - With receive flow on, a received halt pair stops host bytes on our transmitter, a resume pair restarts them.
// - All four flow characters are separately programmable 8-bit values.
// - Recognised flow characters are dropped and never written into the receive fifo.
// - Preset trigger of sixteen gives a halt level of 16 and a resume level of 8.
// - Fill level may overshoot a threshold by a few characters while a pair goes out.
// - With the fifo disabled only one byte is buffered and a second one overruns.
module uart_inband_flow (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic rxValid, // received byte strobe
  input wire logic [7:0] rxData, // received byte
  output logic txOutValid, // byte offered to the transmitter
  output logic [7:0] txOutData, // byte to transmit
  input wire logic txOutReady // transmitter takes the byte
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  uart_flow_pkg::ctrl_s fifoControlReg_ff;
  uart_flow_pkg::chars_s chars_ff;
  uart_flow_pkg::seq_e seqSt_ff;
  logic [7:0] awAddr_ff, arAddr_ff, txHold_ff, pendChar_ff, spillData_ff, seqSecond_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic awHave_ff, wHave_ff, rdPend_ff, popOk_ff, overrun_ff, txHoldValid_ff;
  logic pendValid_ff, spillValid_ff, txHalted_ff, peerHalted_ff, seqHalt_ff;
  logic [uart_flow_pkg::PTR_W-1:0] wrPtr_ff, rdPtr_ff;
  logic [uart_flow_pkg::CNT_W-1:0] count_ff, haltLvl, resumeLvl;
  logic [7:0] memRd;

  logic doWrite, flush, full, pushNow, popNow, haltEv, resumeEv, setPend, clrPend, setSpill;
  logic outFree, needHalt, needResume, hostLoad, txFlow, rxFlow;
  logic [7:0] pushData;

  assign rxFlow = fifoControlReg_ff.inbandFlowSelect & fifoControlReg_ff.rxDualCharFlowCombo;
  assign txFlow = fifoControlReg_ff.inbandFlowSelect & fifoControlReg_ff.txDualCharFlowCombo;
  assign doWrite = awHave_ff & wHave_ff & ~s_axi_bvalid;
  assign flush = doWrite & (awAddr_ff == uart_flow_pkg::OFF_CTRL) & wStrb_ff[0]
    & wData_ff[uart_flow_pkg::CTRL_FLUSH_BIT];
  assign full = fifoControlReg_ff.fifoEn ? (count_ff == uart_flow_pkg::FIFO_FULL_CNT)
    : (count_ff >= uart_flow_pkg::SINGLE_FULL_CNT);
  assign popNow = rdPend_ff & popOk_ff;
  assign outFree = ~txOutValid | txOutReady;

  uart_fifo_mem u_mem (
    .clk(clk),
    .wrEn(pushNow & ~full),
    .wrAddr(wrPtr_ff),
    .wrData(pushData),
    .rdAddr(rdPtr_ff),
    .rdData_ff(memRd)
  );

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHave_ff <= 1'b0;
      wHave_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= uart_flow_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_ff <= s_axi_awaddr;
        awHave_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        wHave_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_ff <= 1'b0;
        wHave_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff > uart_flow_pkg::OFF_TXDATA || awAddr_ff[1:0] != 2'h0)
          ? uart_flow_pkg::RESP_SLVERR : uart_flow_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // only byte lane 0 steers ctrl; chars honour every lane
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fifoControlReg_ff <= uart_flow_pkg::CTRL_RESET;
      chars_ff <= uart_flow_pkg::CHARS_RESET;
    end else if (doWrite) begin
      if (awAddr_ff == uart_flow_pkg::OFF_CTRL && wStrb_ff[0]) begin
        fifoControlReg_ff <= uart_flow_pkg::ctrl_s'(wData_ff[uart_flow_pkg::CTRL_W-1:0]);
      end
      if (awAddr_ff == uart_flow_pkg::OFF_CHARS) begin
        for (int i = 0; i < 4; i++) begin
          if (wStrb_ff[i]) begin
            chars_ff[8*i +: 8] <= wData_ff[8*i +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= uart_flow_pkg::RESP_OKAY;
      rdPend_ff <= 1'b0;
      popOk_ff <= 1'b0;
      arAddr_ff <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        arAddr_ff <= s_axi_araddr;
        s_axi_arready <= 1'b0;
        rdPend_ff <= 1'b1;
        // emptiness judged here: memory data for a byte written now is not yet visible
        popOk_ff <= (s_axi_araddr == uart_flow_pkg::OFF_RXDATA) && (count_ff != 6'h00);
      end
      if (rdPend_ff) begin
        rdPend_ff <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= uart_flow_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        unique case (arAddr_ff)
          uart_flow_pkg::OFF_CTRL: s_axi_rdata <= {25'h0, fifoControlReg_ff};
          uart_flow_pkg::OFF_CHARS: s_axi_rdata <= chars_ff;
          uart_flow_pkg::OFF_STATUS: s_axi_rdata <= {20'h0, peerHalted_ff, txHalted_ff,
            txHoldValid_ff, overrun_ff, 2'h0, count_ff};
          uart_flow_pkg::OFF_RXDATA: s_axi_rdata <= {23'h0, popOk_ff, memRd};
          uart_flow_pkg::OFF_TXDATA: s_axi_rdata <= {24'h0, txHold_ff};
          default: s_axi_rresp <= uart_flow_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive recognition
  // ----------------------------------------------------------------
  always_comb begin
    pushNow = 1'b0;
    pushData = rxData;
    haltEv = 1'b0;
    resumeEv = 1'b0;
    setPend = 1'b0;
    clrPend = 1'b0;
    setSpill = 1'b0;
    if (spillValid_ff) begin
      pushNow = 1'b1;
      pushData = spillData_ff;
    end else if (rxValid) begin
      if (!rxFlow) begin
        pushNow = 1'b1;
      end else if (pendValid_ff) begin
        clrPend = 1'b1;
        if (pendChar_ff == chars_ff.haltFirst && rxData == chars_ff.haltSecond) begin
          haltEv = 1'b1;
        end else if (pendChar_ff == chars_ff.resumeFirst && rxData == chars_ff.resumeSecond) begin
          resumeEv = 1'b1;
        end else begin
          pushNow = 1'b1;
          pushData = pendChar_ff;
          if (rxData == chars_ff.haltFirst || rxData == chars_ff.resumeFirst) begin
            setPend = 1'b1;
          end else begin
            setSpill = 1'b1;
          end
        end
      end else if (rxData == chars_ff.haltFirst || rxData == chars_ff.resumeFirst) begin
        setPend = 1'b1;
      end else begin
        pushNow = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pendValid_ff <= 1'b0;
      pendChar_ff <= 8'h00;
      spillValid_ff <= 1'b0;
      spillData_ff <= 8'h00;
      txHalted_ff <= 1'b0;
    end else begin
      spillValid_ff <= setSpill;
      if (setSpill) begin
        spillData_ff <= rxData;
      end
      if (setPend) begin
        pendValid_ff <= 1'b1;
        pendChar_ff <= rxData;
      end else if (clrPend || !rxFlow) begin
        pendValid_ff <= 1'b0;
      end
      if (haltEv) begin
        txHalted_ff <= 1'b1;
      end else if (resumeEv || !rxFlow) begin
        txHalted_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // fifo pointers and overrun
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= 5'h00;
      rdPtr_ff <= 5'h00;
      count_ff <= 6'h00;
    end else if (flush) begin
      wrPtr_ff <= 5'h00;
      rdPtr_ff <= 5'h00;
      count_ff <= 6'h00;
    end else begin
      if (pushNow && !full) begin
        wrPtr_ff <= wrPtr_ff + 5'h01;
      end
      if (popNow) begin
        rdPtr_ff <= rdPtr_ff + 5'h01;
      end
      count_ff <= count_ff + {5'h00, pushNow & ~full} - {5'h00, popNow};
    end
  end

  // a new overrun in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_ff <= 1'b0;
    end else if (pushNow && full) begin
      overrun_ff <= 1'b1;
    end else if (doWrite && awAddr_ff == uart_flow_pkg::OFF_STATUS && wStrb_ff[1]
      && wData_ff[uart_flow_pkg::STAT_OVR_BIT]) begin
      overrun_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit side: flow pairs ahead of host data
  // ----------------------------------------------------------------
  always_comb begin
    haltLvl = uart_flow_pkg::LVL_SIXTEEN;
    resumeLvl = uart_flow_pkg::LVL_EIGHT;
    unique case (fifoControlReg_ff.trigSel)
      uart_flow_pkg::TRIG_ONE: begin
        haltLvl = uart_flow_pkg::LVL_ONE;
        resumeLvl = uart_flow_pkg::LVL_ZERO;
      end
      uart_flow_pkg::TRIG_FOUR: begin
        haltLvl = uart_flow_pkg::LVL_FOUR;
        resumeLvl = uart_flow_pkg::LVL_ONE;
      end
      uart_flow_pkg::TRIG_EIGHT: begin
        haltLvl = uart_flow_pkg::LVL_EIGHT;
        resumeLvl = uart_flow_pkg::LVL_FOUR;
      end
      uart_flow_pkg::RX_TRIGGER_SIXTEEN: begin
        haltLvl = uart_flow_pkg::LVL_SIXTEEN;
        resumeLvl = uart_flow_pkg::LVL_EIGHT;
      end
    endcase
  end

  // levels are judged only when a pair may start, so the fill level can overshoot
  assign needHalt = txFlow & fifoControlReg_ff.usePresetRxTrigger & ~peerHalted_ff
    & (count_ff >= haltLvl);
  assign needResume = txFlow & peerHalted_ff
    & (~fifoControlReg_ff.usePresetRxTrigger | (count_ff <= resumeLvl));
  assign hostLoad = (seqSt_ff == uart_flow_pkg::SEQ_IDLE) & ~needHalt & ~needResume
    & outFree & txHoldValid_ff & ~txHalted_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seqSt_ff <= uart_flow_pkg::SEQ_IDLE;
      txOutValid <= 1'b0;
      txOutData <= 8'h00;
      seqSecond_ff <= 8'h00;
      seqHalt_ff <= 1'b0;
      peerHalted_ff <= 1'b0;
    end else begin
      if (outFree) begin
        txOutValid <= 1'b0;
      end
      if (!txFlow) begin
        peerHalted_ff <= 1'b0;
      end
      unique case (seqSt_ff)
        uart_flow_pkg::SEQ_IDLE: begin
          if (outFree && (needHalt || needResume)) begin
            txOutValid <= 1'b1;
            txOutData <= needHalt ? chars_ff.haltFirst : chars_ff.resumeFirst;
            seqSecond_ff <= needHalt ? chars_ff.haltSecond : chars_ff.resumeSecond;
            seqHalt_ff <= needHalt;
            seqSt_ff <= uart_flow_pkg::SEQ_SECOND;
          end else if (hostLoad) begin
            txOutValid <= 1'b1;
            txOutData <= txHold_ff;
          end
        end
        uart_flow_pkg::SEQ_SECOND: begin
          if (outFree) begin
            txOutValid <= 1'b1;
            txOutData <= seqSecond_ff;
            peerHalted_ff <= seqHalt_ff;
            seqSt_ff <= uart_flow_pkg::SEQ_IDLE;
          end
        end
        default: seqSt_ff <= uart_flow_pkg::SEQ_IDLE;
      endcase
    end
  end

  // one-byte host holding register; writes while full are dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txHoldValid_ff <= 1'b0;
      txHold_ff <= 8'h00;
    end else if (hostLoad) begin
      txHoldValid_ff <= 1'b0;
    end else if (doWrite && awAddr_ff == uart_flow_pkg::OFF_TXDATA && wStrb_ff[0]
      && !txHoldValid_ff) begin
      txHoldValid_ff <= 1'b1;
      txHold_ff <= wData_ff[7:0];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence haltFirstOut;
    seqSt_ff == uart_flow_pkg::SEQ_IDLE && outFree && needHalt;
  endsequence
  sequence haltPairOut;
    txOutValid && txOutData == chars_ff.haltFirst && seqSt_ff == uart_flow_pkg::SEQ_SECOND;
  endsequence

  AST_HALT_START: assert property (haltFirstOut |=> haltPairOut)
    else $error("halt level reached but first halt character not offered");
  AST_HALT_SECOND: assert property (haltPairOut ##0 outFree |=>
    txOutValid && txOutData == $past(chars_ff.haltSecond) && peerHalted_ff)
    else $error("second halt character did not follow the first");
  AST_RX_HALT: assert property (pendValid_ff && rxFlow && rxValid && !spillValid_ff
    && pendChar_ff == chars_ff.haltFirst && rxData == chars_ff.haltSecond
    |=> txHalted_ff && !pendValid_ff)
    else $error("received halt pair did not stop the transmitter");
  AST_NO_HOST_WHILE_HALTED: assert property (txHalted_ff |=> !$fell(txHoldValid_ff))
    else $error("host byte sent while transmitter halted");
  AST_CHARS_WRITE: assert property (doWrite && awAddr_ff == uart_flow_pkg::OFF_CHARS
    && wStrb_ff == 4'hf |=> chars_ff == $past(wData_ff))
    else $error("flow character register did not take written value");
  AST_DROP_FIRST: assert property (rxValid && rxFlow && !pendValid_ff && !spillValid_ff
    && rxData == chars_ff.haltFirst |-> !pushNow ##1 pendValid_ff)
    else $error("flow character written into the fifo");
  AST_PRESET16: assert property (fifoControlReg_ff.trigSel == uart_flow_pkg::RX_TRIGGER_SIXTEEN
    |-> haltLvl == 6'h10 && resumeLvl == 6'h08)
    else $error("preset sixteen levels wrong");
  AST_SINGLE_BYTE: assert property (!fifoControlReg_ff.fifoEn && count_ff == 6'h01
    && pushNow && !popNow && !flush |=> overrun_ff && count_ff == 6'h01)
    else $error("second byte without fifo did not overrun");
  AST_PEND_RELEASE: assert property (pendValid_ff && rxValid && !spillValid_ff && rxFlow
    && !(pendChar_ff == chars_ff.haltFirst && rxData == chars_ff.haltSecond)
    && !(pendChar_ff == chars_ff.resumeFirst && rxData == chars_ff.resumeSecond)
    |-> pushNow && pushData == pendChar_ff)
    else $error("unmatched pending character not treated as data");

endmodule : uart_inband_flow
